// >>> verilog/pss_pkg.sv
// Package of constants and types for the parameter set sequencer
package pss_pkg;
    localparam int NUM_SETS = 64;
    localparam int IDX_W = 6;
    localparam int TOTAL_W = 7;
    localparam int EXEC_W = 8;
    localparam int LINE_W = 4;
    localparam int LSEL_W = 2;
    localparam int NUM_TIMERS = 4;

    // Field widths of one sequence set
    localparam int EXPO_W = 20;
    localparam int FR_EN_W = 1;
    localparam int FR_W = 16;
    localparam int AOI_W = 12;
    localparam int CENTER_W = 2;
    localparam int BIN_W = 3;
    localparam int PIXFMT_W = 6;
    localparam int TEST_W = 3;
    localparam int GAIN_W = 12;
    localparam int RAW_W = 1;
    localparam int BLACK_W = 10;
    localparam int SHIFT_W = 3;
    localparam int LUT_W = 1;
    localparam int COLOR_W = 24;
    localparam int CHUNK_W = 2;
    localparam int TDLY_W = 16;
    localparam int TDUR_W = 16;
    localparam int TBASE_W = 8;
    localparam int TIMER_W = TDLY_W + TDUR_W + 2 * TBASE_W;

    // Field positions, packed from bit 0 upward
    localparam int EXPO_POS = 0;
    localparam int FR_EN_POS = EXPO_POS + EXPO_W;
    localparam int FR_POS = FR_EN_POS + FR_EN_W;
    localparam int WIDTH_POS = FR_POS + FR_W;
    localparam int HEIGHT_POS = WIDTH_POS + AOI_W;
    localparam int XOFF_POS = HEIGHT_POS + AOI_W;
    localparam int YOFF_POS = XOFF_POS + AOI_W;
    localparam int CENTER_POS = YOFF_POS + AOI_W;
    localparam int BINH_POS = CENTER_POS + CENTER_W;
    localparam int BINV_POS = BINH_POS + BIN_W;
    localparam int PIXFMT_POS = BINV_POS + BIN_W;
    localparam int TEST_POS = PIXFMT_POS + PIXFMT_W;
    localparam int GAIN_POS = TEST_POS + TEST_W;
    localparam int RAW_POS = GAIN_POS + GAIN_W;
    localparam int BLACK_POS = RAW_POS + RAW_W;
    localparam int SHIFT_POS = BLACK_POS + BLACK_W;
    localparam int LUT_POS = SHIFT_POS + SHIFT_W;
    localparam int COLOR_POS = LUT_POS + LUT_W;
    localparam int CHUNK_POS = COLOR_POS + COLOR_W;
    localparam int TIMER_POS = CHUNK_POS + CHUNK_W;
    localparam int SET_W = TIMER_POS + NUM_TIMERS * TIMER_W;

    localparam logic [SET_W-1:0] SET_RESET = '0;
    localparam logic [IDX_W-1:0] FIRST_SET = 6'h00;
    localparam logic [TOTAL_W-1:0] MAX_TOTAL = 7'h40;
    localparam logic [EXEC_W-1:0] EXEC_MIN = 8'h01;

    typedef enum logic [1:0] {
        PSS_MODE_AUTO = 2'b00,
        PSS_MODE_CTRL = 2'b01,
        PSS_MODE_FREE = 2'b10
    } pss_mode_t;

    typedef enum logic [1:0] {
        PSS_SRC_ALWAYS = 2'b00,
        PSS_SRC_LINE = 2'b01,
        PSS_SRC_DISABLED = 2'b10
    } pss_src_t;
endpackage

// >>> verilog/pss_sequencer.sv
// Parameter set sequencer: stored sets swapped into the active configuration
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] Sequencer stays inactive while averaging or auto exposure/gain is enabled.
// [R2] Only sequence parameters are replaced; non-sequence parameters never pass through here.
// [R3] A set is swapped in one cycle, so frame rate is never reduced.
// [R4] Each set holds imaging fields plus delay, duration, timebases per timer 1-4.
// [R5] Per-set use count is honoured only in automatic mode.
// [R6] Sets are addressed by index starting at zero.
// [R7] While enabled, reads show pre-enable values; set contents are not readable or writable.
// [R8] Host disables the sequencer before writing set contents.
// [R9] Sets live in flip-flops cleared by reset.
// [R10] Set contents are never offered to the user-set save path.
// [R11] Current set is chosen on frame triggers, except for software advance/skip/restart.
// [R12] Automatic mode steps ascending, repeats per use count, wraps after the last.
// [R13] Controlled mode advance is gated: always, an input line, or software only.
// [R14] Free selection mode takes the set index straight from the input lines.
// [R15] Restart starts a fresh cycle; by line in controlled mode, or software.
// [R16] Software skip command jumps over the next set to the one after.
// [R17] Line-driven advance and restart sample the line only at a frame trigger.
// [R18] Software advance and restart act at once, independent of frame triggers.
// [R19] When chunks are enabled each frame carries the index of its set.
// [R20] Enabling loads set 0 and uses it for the next triggered acquisition, except in free selection mode.
// [R21] Number of sets in a cycle is programmable up to 64.
// [R22] In automatic mode, after the last set is used up, set 0 follows.
// [R23] Selected set is applied by the cycle in which acquisition starts.
module pss_sequencer
    import pss_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic seq_enable_in,
    input wire logic averaging_en_in,
    input wire logic auto_func_en_in,
    input wire logic [1:0] adv_mode_in,
    input wire logic [1:0] adv_source_in,
    input wire logic [LSEL_W-1:0] adv_line_sel_in,
    input wire logic restart_line_en_in,
    input wire logic [LSEL_W-1:0] restart_line_sel_in,
    input wire logic [TOTAL_W-1:0] total_sets_in,
    input wire logic chunk_en_in,
    input wire logic [LINE_W-1:0] lines_in,
    input wire logic frame_trig_in,
    input wire logic sw_advance_in,
    input wire logic sw_skip_in,
    input wire logic sw_restart_in,
    input wire logic set_wr_in,
    input wire logic set_rd_in,
    input wire logic [IDX_W-1:0] set_idx_in,
    input wire logic [SET_W-1:0] set_data_in,
    input wire logic [EXEC_W-1:0] set_exec_in,
    input wire logic cfg_wr_in,
    input wire logic [SET_W-1:0] cfg_data_in,
    output logic [SET_W-1:0] set_rd_data_out,
    output logic [EXEC_W-1:0] set_rd_exec_out,
    output logic [SET_W-1:0] cfg_rd_data_out,
    output logic [SET_W-1:0] active_cfg_out,
    output logic seq_active_out,
    output logic [IDX_W-1:0] current_set_out,
    output logic acq_start_out,
    output logic chunk_valid_out,
    output logic [IDX_W-1:0] chunk_index_out
);

    typedef struct packed {
        logic [NUM_SETS-1:0][SET_W-1:0] sets;
        logic [NUM_SETS-1:0][EXEC_W-1:0] execs;
        logic [SET_W-1:0] host_cfg;
        logic [SET_W-1:0] active;
        logic [SET_W-1:0] rd_data;
        logic [EXEC_W-1:0] rd_exec;
        logic [IDX_W-1:0] cur;
        logic [EXEC_W-1:0] use_cnt;
        logic fresh;
        logic en_q;
        logic [LINE_W-1:0] ln1;
        logic [LINE_W-1:0] ln2;
        logic [LINE_W-1:0] ln3;
        logic [LINE_W-1:0] lnf;
        logic acq_start;
        logic chunk_valid;
        logic [IDX_W-1:0] chunk_idx;
    } pss_state_t;

    pss_state_t st;
    pss_state_t next_st;

    // Total sets clamped to 1..64
    function automatic logic [TOTAL_W-1:0] eff_total(input logic [TOTAL_W-1:0] t);
        if (t == '0)
        begin
            return 7'h01;
        end
        else if (t > MAX_TOTAL)
        begin
            return MAX_TOTAL; // [R21]
        end
        return t;
    endfunction

    // Next index in ascending order with wrap to set 0
    function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i,
                                                  input logic [TOTAL_W-1:0] t);
        logic [TOTAL_W-1:0] nxt;
        nxt = {1'b0, i} + 7'h01;
        if (nxt >= eff_total(t))
        begin
            return FIRST_SET; // [R12] [R22]
        end
        return nxt[IDX_W-1:0];
    endfunction

    logic en;
    logic [IDX_W-1:0] base;
    logic fresh_b;
    logic [EXEC_W-1:0] cnt_b;
    logic [IDX_W-1:0] sel;
    logic [EXEC_W-1:0] cnt_sel;
    logic [EXEC_W-1:0] exec_cur;
    logic restart_line;
    logic adv_line;
    logic [TOTAL_W-1:0] free_idx;
    logic sw_ok;
    logic do_restart;
    logic do_skip;
    logic do_advance;

    assign en = seq_enable_in & ~averaging_en_in & ~auto_func_en_in; // [R1]
    assign restart_line = restart_line_en_in & st.lnf[restart_line_sel_in]; // [R17]
    assign adv_line = st.lnf[adv_line_sel_in]; // [R17]
    assign free_idx = {{(TOTAL_W - LINE_W){1'b0}}, st.lnf};

    // Software commands only steer the auto and controlled cycles
    assign sw_ok = (adv_mode_in == PSS_MODE_AUTO) || (adv_mode_in == PSS_MODE_CTRL); // [R15]
    assign do_restart = sw_ok & sw_restart_in;
    assign do_skip = sw_ok & sw_skip_in; // [R16]
    assign do_advance = sw_ok & sw_advance_in;

    always_comb
    begin
        next_st = st;
        next_st.acq_start = 1'b0;
        next_st.chunk_valid = 1'b0;
        next_st.en_q = en;
        base = st.cur;
        fresh_b = st.fresh;
        cnt_b = st.use_cnt;
        sel = st.cur;
        cnt_sel = st.use_cnt;
        exec_cur = EXEC_MIN;

        // Input lines: three stages, accept a change once stages two and three agree
        next_st.ln1 = lines_in;
        next_st.ln2 = st.ln1;
        next_st.ln3 = st.ln2;
        if (st.ln2 == st.ln3)
        begin
            next_st.lnf = st.ln3;
        end

        if (!en)
        begin
            // Set storage and host view only while the sequencer is off
            if (set_wr_in)
            begin
                next_st.sets[set_idx_in] = set_data_in; // [R4] [R6] [R8]
                next_st.execs[set_idx_in] = set_exec_in;
            end
            if (set_rd_in)
            begin
                next_st.rd_data = st.sets[set_idx_in]; // [R6]
                next_st.rd_exec = st.execs[set_idx_in];
            end
            if (cfg_wr_in)
            begin
                next_st.host_cfg = cfg_data_in;
            end
            next_st.active = next_st.host_cfg;
            next_st.fresh = 1'b1;
        end
        else if (!st.en_q)
        begin
            // Cycle starts with set 0 already applied
            next_st.cur = FIRST_SET; // [R20]
            next_st.active = st.sets[FIRST_SET]; // [R20] [R2]
            next_st.use_cnt = '0;
            next_st.fresh = 1'b1;
            next_st.rd_data = SET_RESET; // [R7]
            next_st.rd_exec = '0;
        end
        else
        begin
            // Software commands act at once, outside the frame timing
            if (do_restart)
            begin
                base = FIRST_SET; // [R15] [R18]
                fresh_b = 1'b1;
                cnt_b = '0;
            end
            else if (do_skip)
            begin
                base = next_idx(next_idx(st.cur, total_sets_in), total_sets_in); // [R16] [R18]
                fresh_b = 1'b1;
                cnt_b = '0;
            end
            else if (do_advance)
            begin
                base = next_idx(st.cur, total_sets_in); // [R18]
                fresh_b = 1'b1;
                cnt_b = '0;
            end

            sel = base;
            cnt_sel = cnt_b;

            if (frame_trig_in)
            begin
                // Selection on the frame trigger
                unique case (adv_mode_in) // [R11]
                    PSS_MODE_AUTO:
                    begin
                        exec_cur = st.execs[base]; // [R5]
                        if (exec_cur == '0)
                        begin
                            exec_cur = EXEC_MIN;
                        end
                        if (fresh_b)
                        begin
                            sel = base;
                            cnt_sel = EXEC_MIN;
                        end
                        else if (cnt_b >= exec_cur)
                        begin
                            sel = next_idx(base, total_sets_in); // [R12] [R22]
                            cnt_sel = EXEC_MIN;
                        end
                        else
                        begin
                            sel = base; // [R12]
                            cnt_sel = cnt_b + EXEC_MIN;
                        end
                    end
                    PSS_MODE_CTRL:
                    begin
                        cnt_sel = '0;
                        // Line restart wins over any advance
                        if (restart_line)
                        begin
                            sel = FIRST_SET; // [R15] [R17]
                        end
                        else if (fresh_b)
                        begin
                            sel = base;
                        end
                        else
                        begin
                            // Advance gated by the chosen source
                            unique case (adv_source_in) // [R13]
                                PSS_SRC_ALWAYS:
                                begin
                                    sel = next_idx(base, total_sets_in);
                                end
                                PSS_SRC_LINE:
                                begin
                                    if (adv_line)
                                    begin
                                        sel = next_idx(base, total_sets_in); // [R17]
                                    end
                                end
                                PSS_SRC_DISABLED:
                                begin
                                    sel = base;
                                end
                                default:
                                begin
                                    sel = base;
                                end
                            endcase
                        end
                    end
                    PSS_MODE_FREE:
                    begin
                        cnt_sel = '0;
                        // Lines beyond the cycle keep the current set
                        if (free_idx < eff_total(total_sets_in))
                        begin
                            sel = free_idx[IDX_W-1:0]; // [R14]
                        end
                    end
                    default:
                    begin
                        sel = base;
                    end
                endcase
                // Selection and its acquisition pulse leave together
                next_st.cur = sel;
                next_st.use_cnt = cnt_sel;
                next_st.fresh = 1'b0;
                next_st.active = st.sets[sel]; // [R2] [R3] [R23]
                next_st.acq_start = 1'b1; // [R23]
                next_st.chunk_valid = chunk_en_in; // [R19]
                next_st.chunk_idx = sel; // [R19]
            end
            else if (fresh_b != st.fresh || base != st.cur)
            begin
                // Command with no trigger applies at once
                next_st.cur = base;
                next_st.use_cnt = cnt_b;
                next_st.fresh = fresh_b;
                next_st.active = st.sets[base]; // [R18]
            end
        end
    end

    // All sets cleared by reset; no path carries them to a saved user set
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0; // [R9] [R10]
        end
        else
        begin
            st <= next_st;
        end
    end

    assign set_rd_data_out = st.rd_data;
    assign set_rd_exec_out = st.rd_exec;
    assign cfg_rd_data_out = st.host_cfg; // [R7]
    assign active_cfg_out = st.active;
    assign seq_active_out = st.en_q;
    assign current_set_out = st.cur;
    assign acq_start_out = st.acq_start;
    assign chunk_valid_out = st.chunk_valid;
    assign chunk_index_out = st.chunk_idx;

endmodule // pss_sequencer

`default_nettype wire

// >>> testbench/pss_assertions.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pss_assertions
    import pss_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic seq_enable_in,
    input wire logic averaging_en_in,
    input wire logic auto_func_en_in,
    input wire logic [1:0] adv_mode_in,
    input wire logic chunk_en_in,
    input wire logic frame_trig_in,
    input wire logic sw_restart_in,
    input wire logic [SET_W-1:0] cfg_rd_data_out,
    input wire logic seq_active_out,
    input wire logic [IDX_W-1:0] current_set_out,
    input wire logic acq_start_out,
    input wire logic chunk_valid_out,
    input wire logic [IDX_W-1:0] chunk_index_out
);
    wire logic en;
    assign en = seq_enable_in && !averaging_en_in && !auto_func_en_in;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_block;
        averaging_en_in || auto_func_en_in |=> !seq_active_out;
    endproperty
    a_block: assert property (p_block) else $error("active while blocked");
    property p_first;
        $rose(seq_active_out) |-> current_set_out == FIRST_SET;
    endproperty
    a_first: assert property (p_first) else $error("enable did not select set 0");
    property p_acq;
        en && seq_active_out && frame_trig_in |=> acq_start_out;
    endproperty
    a_acq: assert property (p_acq) else $error("trigger without acquisition");
    property p_noacq;
        !(seq_active_out && frame_trig_in) |=> !acq_start_out;
    endproperty
    a_noacq: assert property (p_noacq) else $error("acquisition without trigger");
    property p_chunk;
        chunk_valid_out == (acq_start_out && $past(chunk_en_in));
    endproperty
    a_chunk: assert property (p_chunk) else $error("chunk pulse wrong");
    property p_idx;
        chunk_valid_out |-> chunk_index_out == current_set_out;
    endproperty
    a_idx: assert property (p_idx) else $error("chunk index differs from set");
    property p_restart;
        en && seq_active_out && sw_restart_in && !adv_mode_in[1] |=> current_set_out == FIRST_SET;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not select set 0");
    property p_hide;
        en && seq_active_out |=> $stable(cfg_rd_data_out);
    endproperty
    a_hide: assert property (p_hide) else $error("host view changed while enabled");
endmodule // pss_assertions
`default_nettype wire

// >>> testbench/pss_line_model.sv
// Camera input lines driven off the clock grid
`timescale 1ns/1ps
`default_nettype none
module pss_line_model
    import pss_pkg::*;
(
    input wire logic [LINE_W-1:0] level_in,
    output wire logic [LINE_W-1:0] lines_out
);
    // Lines move asynchronously to the sequencer clock
    assign #7 lines_out = level_in;
endmodule // pss_line_model
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the parameter set sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pss_pkg::*;
    logic clk_sys_in, rst_n_in, seq_enable_in, averaging_en_in, auto_func_en_in, chunk_en_in;
    logic [1:0] adv_mode_in, adv_source_in, adv_line_sel_in, restart_line_sel_in;
    logic restart_line_en_in, frame_trig_in, sw_advance_in, sw_skip_in, sw_restart_in;
    logic set_wr_in, set_rd_in, cfg_wr_in, seq_active_out, acq_start_out, chunk_valid_out;
    logic [TOTAL_W-1:0] total_sets_in;
    logic [LINE_W-1:0] line_level;
    wire logic [LINE_W-1:0] lines_in;
    logic [IDX_W-1:0] set_idx_in, current_set_out, chunk_index_out;
    logic [SET_W-1:0] set_data_in, cfg_data_in, set_rd_data_out, cfg_rd_data_out, active_cfg_out;
    logic [EXEC_W-1:0] set_exec_in, set_rd_exec_out;
    int fails = 0;
    int checks = 0;
    int auto_exp[6] = '{0, 1, 1, 1, 2, 0};
    pss_sequencer dut (.*);
    pss_line_model lm (.level_in(line_level), .lines_out(lines_in));
    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [SET_W-1:0] setv(input int i);
        setv = SET_W'({64{i[7:0] + 8'h5a}});
    endfunction
    task automatic test_done;
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [SET_W-1:0] g, input logic [SET_W-1:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input int i, input logic [SET_W-1:0] d, input int x);
        @(posedge clk_sys_in);
        set_wr_in <= 1'b1;
        set_idx_in <= IDX_W'(i);
        set_data_in <= d;
        set_exec_in <= EXEC_W'(x);
        @(posedge clk_sys_in);
        set_wr_in <= 1'b0;
    endtask
    task automatic rd(input int i, input logic [SET_W-1:0] d, input int x);
        @(posedge clk_sys_in);
        set_rd_in <= 1'b1;
        set_idx_in <= IDX_W'(i);
        @(posedge clk_sys_in);
        set_rd_in <= 1'b0;
        #1;
        chk(set_rd_data_out, d);
        chk(set_rd_exec_out, EXEC_W'(x));
    endtask
    task automatic cw(input logic [SET_W-1:0] d);
        @(posedge clk_sys_in);
        cfg_wr_in <= 1'b1;
        cfg_data_in <= d;
        @(posedge clk_sys_in);
        cfg_wr_in <= 1'b0;
        #1;
    endtask
    task automatic trig(input logic a, input int e);
        @(posedge clk_sys_in);
        frame_trig_in <= 1'b1;
        @(posedge clk_sys_in);
        frame_trig_in <= 1'b0;
        #1;
        chk(acq_start_out, a);
        chk(chunk_valid_out, a & chunk_en_in);
        if (a && e >= 0)
        begin
            chk(current_set_out, e);
            chk(chunk_index_out, e);
            chk(active_cfg_out, setv(e));
        end
    endtask
    task automatic cmd(input int k, input int e);
        @(posedge clk_sys_in);
        {sw_restart_in, sw_skip_in, sw_advance_in} <= 3'b001 << k;
        @(posedge clk_sys_in);
        {sw_restart_in, sw_skip_in, sw_advance_in} <= 3'b000;
        #1;
        chk(current_set_out, e);
    endtask
    task automatic lv(input logic [LINE_W-1:0] v);
        @(posedge clk_sys_in);
        line_level <= v;
        repeat (10) @(posedge clk_sys_in);
    endtask
    task automatic start(input pss_mode_t m, input pss_src_t s, input int t);
        @(posedge clk_sys_in);
        seq_enable_in <= 1'b0;
        adv_mode_in <= m;
        adv_source_in <= s;
        total_sets_in <= TOTAL_W'(t);
        @(posedge clk_sys_in);
        seq_enable_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chk(seq_active_out, 1'b1);
        chk(current_set_out, 0);
        chk(active_cfg_out, setv(0));
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        test_done;
    end
    initial
    begin
        {seq_enable_in, averaging_en_in, auto_func_en_in, adv_mode_in, adv_source_in} = '0;
        {adv_line_sel_in, total_sets_in, line_level, frame_trig_in, sw_advance_in} = '0;
        {sw_skip_in, sw_restart_in, set_wr_in, set_rd_in, set_idx_in, cfg_wr_in} = '0;
        {set_data_in, cfg_data_in, set_exec_in} = '0;
        restart_line_en_in = 1'b1;
        restart_line_sel_in = 2'h1;
        chunk_en_in = 1'b1;
        rst_n_in = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(1, '0, 0);
        for (int i = 0; i < 4; i++)
            wr(i, setv(i), i == 1 ? 3 : 1);
        rd(1, setv(1), 3);
        cw(setv(9));
        chk(cfg_rd_data_out, setv(9));
        start(PSS_MODE_AUTO, PSS_SRC_ALWAYS, 3);
        cw(setv(8));
        chk(cfg_rd_data_out, setv(9));
        wr(0, setv(7), 1);
        foreach (auto_exp[k])
            trig(1'b1, auto_exp[k]);
        trig(1'b1, 1);
        cmd(2, 0);
        trig(1'b1, 0);
        cmd(1, 2);
        trig(1'b1, 2);
        cmd(0, 0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_sys_in);
            {auto_func_en_in, averaging_en_in} <= 2'b01 << k;
            repeat (2) @(posedge clk_sys_in);
            #1;
            chk(seq_active_out, 1'b0);
            trig(1'b0, -1);
            rd(0, setv(0), 1);
        end
        @(posedge clk_sys_in);
        {auto_func_en_in, averaging_en_in} <= 2'b00;
        start(PSS_MODE_CTRL, PSS_SRC_LINE, 3);
        trig(1'b1, 0);
        lv(4'h1);
        trig(1'b1, 1);
        lv(4'h0);
        trig(1'b1, 1);
        lv(4'h2);
        trig(1'b1, 0);
        lv(4'h0);
        start(PSS_MODE_CTRL, PSS_SRC_ALWAYS, 3);
        for (int k = 0; k < 4; k++)
            trig(1'b1, k % 3);
        @(posedge clk_sys_in);
        chunk_en_in <= 1'b0;
        start(PSS_MODE_CTRL, PSS_SRC_DISABLED, 3);
        trig(1'b1, 0);
        trig(1'b1, 0);
        cmd(0, 1);
        trig(1'b1, 1);
        @(posedge clk_sys_in);
        chunk_en_in <= 1'b1;
        start(PSS_MODE_FREE, PSS_SRC_ALWAYS, 4);
        lv(4'h2);
        trig(1'b1, 2);
        trig(1'b1, 2);
        lv(4'h3);
        trig(1'b1, 3);
        lv(4'h7);
        trig(1'b1, 3);
        cmd(2, 3);
        cmd(1, 3);
        @(posedge clk_sys_in);
        rst_n_in <= 1'b0;
        seq_enable_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd(1, '0, 0);
        chk(active_cfg_out, '0);
        test_done;
    end
endmodule // tb_top
bind pss_sequencer pss_assertions u_chk (.*);
`default_nettype wire
